// *** cic_core_interrupt_control.sv ***
// Interrupt flags, enables, entry sequencing and wake logic of an 8-bit core.
// Assumes the core sequencer obeys the pulses and that events are clk-synchronous.
`timescale 1ns/1ns
module cic_core_interrupt_control
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic timer_overflow_evt,
   input wire logic port_change_evt,
   input wire logic [7:0] periph_evt,
   input wire logic aux_evt,
   input wire logic ext_pin,
   input wire logic return_from_irq_op,
   input wire logic nibble_swap_op,
   input wire logic alu_flags_we,
   input wire logic sleep_active,
   input wire logic [12:0] pc_current,
   output logic status_flags_we,
   output logic wake_request,
   output logic flush_prefetch,
   output logic push_pc,
   output logic [12:0] push_addr,
   output logic pop_pc,
   output logic load_vector,
   output logic [12:0] vector_pc,
   output logic [1:0] q_phase
);

   typedef struct packed {
      logic [1:0] q;
      logic [7:0] ctl;
      logic [7:0] pflag;
      logic [7:0] pen;
      logic aux_flag;
      logic aux_en;
      logic edge_sel;
      logic pin_prev;
      logic ext_pend;
      cic_pkg::cic_state_e st;
      logic wake_hold;
      logic wake_q1;
      logic sleep_prev;
      logic [7:0] rdata;
      logic flush;
      logic push;
      logic [12:0] paddr;
      logic pop;
      logic load;
   } cic_state_s;

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_meta_n;
   logic rst_sync_n;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_n <= 1'h0;
         rst_sync_n <= 1'h0;
      end
      else
      begin
         rst_meta_n <= 1'h1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // ****************************************
   // Combinational terms
   // ****************************************
   cic_state_s s;
   cic_state_s next_s;
   logic pin_edge;
   logic pending;
   logic ctl_wr;
   logic sleep_fell;
   logic entry_ok;

   function automatic logic cic_any_req(input logic [7:0] ctl, input logic [7:0] pflag,
                                        input logic [7:0] pen, input logic aux_flag, input logic aux_en);
      logic core_req;
      logic per_req;
      core_req = (ctl[cic_pkg::CIC_BIT_TMR_FLAG] & ctl[cic_pkg::CIC_BIT_TMR_EN])
               | (ctl[cic_pkg::CIC_BIT_EXT_FLAG] & ctl[cic_pkg::CIC_BIT_EXT_EN])
               | (ctl[cic_pkg::CIC_BIT_PORT_FLAG] & ctl[cic_pkg::CIC_BIT_PORT_EN]); // RL23
      per_req = (|(pflag & pen)) | (aux_flag & aux_en);
      cic_any_req = core_req | (per_req & ctl[cic_pkg::CIC_BIT_GRP_EN]); // RL22
   endfunction

   // Edge against the previous sample; polarity from the edge-select bit
   assign pin_edge = s.edge_sel ? (ext_pin & ~s.pin_prev) : (~ext_pin & s.pin_prev); // RL14
   assign pending = cic_any_req(s.ctl, s.pflag, s.pen, s.aux_flag, s.aux_en); // RL2
   assign ctl_wr = reg_wr && (reg_addr == cic_pkg::CIC_OFF_CORE_CTL);
   assign sleep_fell = s.sleep_prev & ~sleep_active;
   // Blocked on the wake Q1 so the instruction after Sleep runs first
   assign entry_ok = s.ctl[cic_pkg::CIC_BIT_GLB_EN] & pending & ~s.wake_hold & ~sleep_fell
                     & ~sleep_active; // RL13

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      next_s = s;
      next_s.q = s.q + 2'h1;
      next_s.pin_prev = ext_pin;
      next_s.sleep_prev = sleep_active;
      next_s.flush = 1'h0;
      next_s.push = 1'h0;
      next_s.pop = 1'h0;
      next_s.load = 1'h0;
      next_s.rdata = 8'h00;

      // Register writes first; hardware sets below win over a clearing write
      if (ctl_wr)
         next_s.ctl = reg_wdata; // RL21
      if (reg_wr && (reg_addr == cic_pkg::CIC_OFF_PERIPH_FLAG))
         next_s.pflag = reg_wdata;
      if (reg_wr && (reg_addr == cic_pkg::CIC_OFF_PERIPH_EN))
         next_s.pen = reg_wdata;
      if (reg_wr && (reg_addr == cic_pkg::CIC_OFF_OPTION))
         next_s.edge_sel = reg_wdata[cic_pkg::CIC_BIT_EDGE_SEL];
      if (reg_wr && (reg_addr == cic_pkg::CIC_OFF_AUX))
      begin
         next_s.aux_flag = reg_wdata[cic_pkg::CIC_BIT_AUX_FLAG];
         next_s.aux_en = reg_wdata[cic_pkg::CIC_BIT_AUX_EN];
      end

      // Flags set whatever the enables say
      if (timer_overflow_evt)
         next_s.ctl[cic_pkg::CIC_BIT_TMR_FLAG] = 1'h1; // RL3
      if (port_change_evt)
         next_s.ctl[cic_pkg::CIC_BIT_PORT_FLAG] = 1'h1; // RL3
      next_s.pflag = next_s.pflag | periph_evt; // RL20
      if (aux_evt)
         next_s.aux_flag = 1'h1; // RL20

      // Pin flag may only land in Q4 or Q1; a later edge waits for Q4
      if (pin_edge)
         next_s.ext_pend = 1'h1; // RL9
      if ((s.q == cic_pkg::CIC_Q4) || (s.q == cic_pkg::CIC_Q1))
      begin
         if (pin_edge || s.ext_pend)
         begin
            next_s.ctl[cic_pkg::CIC_BIT_EXT_FLAG] = 1'h1; // RL15
            next_s.ext_pend = 1'h0; // RL10
         end
      end

      // Return: pop and re-enable together
      if (return_from_irq_op)
      begin
         next_s.pop = 1'h1;
         next_s.ctl[cic_pkg::CIC_BIT_GLB_EN] = 1'h1; // RL6
      end

      // Wake hold lasts until the second Q1 phase after Sleep ends
      if (sleep_fell)
      begin
         next_s.wake_hold = 1'h1;
         next_s.wake_q1 = 1'h0;
      end
      else if (s.wake_hold && (s.q == cic_pkg::CIC_Q1))
      begin
         if (s.wake_q1)
            next_s.wake_hold = 1'h0;
         else
            next_s.wake_q1 = 1'h1;
      end

      // Entry steps on successive Q1 phases: sample, flush/push, vector
      case (s.st)
         cic_pkg::CIC_ST_IDLE:
         begin
            if ((s.q == cic_pkg::CIC_Q1) && entry_ok) // RL7
            begin
               next_s.ctl[cic_pkg::CIC_BIT_GLB_EN] = 1'h0; // RL4
               next_s.st = cic_pkg::CIC_ST_FLUSH;
            end
         end
         cic_pkg::CIC_ST_FLUSH:
         begin
            if (s.q == cic_pkg::CIC_Q1)
            begin
               next_s.flush = 1'h1; // RL4
               next_s.push = 1'h1; // RL16
               next_s.paddr = pc_current; // RL16
               next_s.st = cic_pkg::CIC_ST_VECTOR;
            end
         end
         cic_pkg::CIC_ST_VECTOR:
         begin
            if (s.q == cic_pkg::CIC_Q1)
            begin
               next_s.load = 1'h1; // RL8
               next_s.st = cic_pkg::CIC_ST_IDLE;
            end
         end
         default:
         begin
            next_s.st = cic_pkg::CIC_ST_IDLE;
         end
      endcase

      // Read data in the cycle after the strobe only
      if (reg_rd)
      begin
         case (reg_addr)
            cic_pkg::CIC_OFF_CORE_CTL: next_s.rdata = s.ctl;
            cic_pkg::CIC_OFF_PERIPH_FLAG: next_s.rdata = s.pflag;
            cic_pkg::CIC_OFF_PERIPH_EN: next_s.rdata = s.pen;
            cic_pkg::CIC_OFF_OPTION: next_s.rdata = {1'h0, s.edge_sel, 6'h00};
            cic_pkg::CIC_OFF_AUX: next_s.rdata = {6'h00, s.aux_en, s.aux_flag};
            default: next_s.rdata = 8'h00;
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         s <= '0;
         s.ctl <= cic_pkg::CIC_RST_CORE_CTL; // RL1
         s.pflag <= cic_pkg::CIC_RST_PERIPH;
         s.pen <= cic_pkg::CIC_RST_PERIPH;
         s.edge_sel <= cic_pkg::CIC_RST_EDGE_SEL;
         s.st <= cic_pkg::CIC_ST_IDLE;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign reg_rdata = s.rdata;
   assign flush_prefetch = s.flush;
   assign push_pc = s.push;
   assign push_addr = s.paddr;
   assign pop_pc = s.pop;
   // All 13 counter bits are loaded from vector_pc; the high latch has no write path here
   assign load_vector = s.load; // RL17
   assign vector_pc = cic_pkg::CIC_VECTOR_ADDR; // RL4
   assign q_phase = s.q;
   // Wake ignores the global enable; the core then vectors or continues
   assign wake_request = sleep_active & pending; // RL12
   assign status_flags_we = alu_flags_we & ~nibble_swap_op; // RL18

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_n);

   a_reset_glb_off: assert property (@(posedge clk) $rose(rst_sync_n) |-> !s.ctl[cic_pkg::CIC_BIT_GLB_EN]) // RL1
      else $error("global enable set right after reset");

   a_entry_needs_enable: assert property ((s.st == cic_pkg::CIC_ST_FLUSH) && $past(s.st == cic_pkg::CIC_ST_IDLE)
      |-> $past(s.ctl[cic_pkg::CIC_BIT_GLB_EN]) && $past(pending)) // RL2
      else $error("entry without enabled request");

   a_flag_always_set: assert property (timer_overflow_evt |=> s.ctl[cic_pkg::CIC_BIT_TMR_FLAG]) // RL3
      else $error("timer flag not set by event");

   a_entry_order: assert property (flush_prefetch |-> push_pc && !s.ctl[cic_pkg::CIC_BIT_GLB_EN] ##4 load_vector) // RL4
      else $error("entry sequence out of order");

   a_no_entry_masked: assert property ((s.st == cic_pkg::CIC_ST_IDLE) && !s.ctl[cic_pkg::CIC_BIT_GLB_EN]
      |=> s.st == cic_pkg::CIC_ST_IDLE) // RL5
      else $error("entry taken with global enable clear");

   a_return_sets_glb: assert property (return_from_irq_op && (s.q != cic_pkg::CIC_Q1) && !ctl_wr
      |=> pop_pc && s.ctl[cic_pkg::CIC_BIT_GLB_EN]) // RL6
      else $error("return did not pop and re-enable");

   // Load is registered at the twelfth edge, so it is seen one sample later
   a_sync_latency: assert property (timer_overflow_evt && (s.q == cic_pkg::CIC_Q1) && (s.st == cic_pkg::CIC_ST_IDLE)
      && s.ctl[cic_pkg::CIC_BIT_GLB_EN] && s.ctl[cic_pkg::CIC_BIT_TMR_EN] && !s.wake_hold && !sleep_active
      && !pending && !reg_wr && !return_from_irq_op |-> ##13 load_vector) // RL8
      else $error("synchronous latency not three cycles");

   a_pin_flag_phase: assert property ($rose(s.ctl[cic_pkg::CIC_BIT_EXT_FLAG]) && !$past(ctl_wr)
      |-> ($past(s.q) == cic_pkg::CIC_Q4) || ($past(s.q) == cic_pkg::CIC_Q1)) // RL10
      else $error("pin flag set outside Q4-Q1");

   a_pin_edge_flag: assert property (pin_edge && !ctl_wr |-> ##[1:3] s.ctl[cic_pkg::CIC_BIT_EXT_FLAG]) // RL14
      else $error("valid pin edge lost");

   a_wake_one_instr: assert property (sleep_fell |-> (s.st == cic_pkg::CIC_ST_IDLE) [*5]) // RL13
      else $error("vectoring before post-Sleep instruction");

   a_swap_keeps_flags: assert property (nibble_swap_op |-> !status_flags_we) // RL18
      else $error("nibble swap changed status flags");

endmodule // cic_core_interrupt_control

// *** cic_pkg.sv ***
// Constants, register map and state types of the core interrupt controller.
// Assumes one 250 MHz clock; four clocks form one instruction cycle (Q1..Q4).
// Operation
// RL1: Any reset leaves every interrupt disabled
// RL2: Vector needs global, source and group enables; the timer, pin and port sources here vector without the group enable
// RL3: Flags set regardless of any enable
// RL4: Entry flushes, clears global, pushes, loads 0004h
// RL5: Global clear: flags set, no vectoring
// RL6: Return pops address and sets global enable
// RL7: Flag pending under disable vectors once re-enabled
// RL8: Synchronous latency exactly three instruction cycles
// RL9: Asynchronous latency three to four cycles
// RL10: Pin flag set in Q4-Q1, sampled Q1
// RL11: Software enables wake sources before Sleep
// RL12: Wake vectors if global set, else continues
// RL13: Instruction after Sleep completes before vectoring
// RL14: Pin edge chosen by edge-select bit
// RL15: Pin edge sets flag; vectors with enables
// RL16: Only return address saved on entry
// RL17: Vector load leaves high latch unchanged
// RL18: Nibble swap leaves status flags untouched
// RL19: Software clears serviced flags before return
// RL20: Twelve sources, each with enable and flag
// RL21: Control bits global enable down to port flag
// RL22: Peripheral sources also gated by group enable
// RL23: Request is OR of flag-and-enable terms
package cic_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [2:0] CIC_OFF_CORE_CTL = 3'h0;
   localparam logic [2:0] CIC_OFF_PERIPH_FLAG = 3'h1;
   localparam logic [2:0] CIC_OFF_PERIPH_EN = 3'h2;
   localparam logic [2:0] CIC_OFF_OPTION = 3'h3;
   localparam logic [2:0] CIC_OFF_AUX = 3'h4;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CIC_BIT_GLB_EN = 7;
   localparam int CIC_BIT_GRP_EN = 6;
   localparam int CIC_BIT_TMR_EN = 5;
   localparam int CIC_BIT_EXT_EN = 4;
   localparam int CIC_BIT_PORT_EN = 3;
   localparam int CIC_BIT_TMR_FLAG = 2;
   localparam int CIC_BIT_EXT_FLAG = 1;
   localparam int CIC_BIT_PORT_FLAG = 0;
   localparam int CIC_BIT_EDGE_SEL = 6;
   localparam int CIC_BIT_AUX_FLAG = 0;
   localparam int CIC_BIT_AUX_EN = 1;

   // ****************************************
   // Reset values and timing
   // ****************************************
   localparam logic [7:0] CIC_RST_CORE_CTL = 8'h00;
   localparam logic [7:0] CIC_RST_PERIPH = 8'h00;
   localparam logic CIC_RST_EDGE_SEL = 1'h1;
   localparam logic [12:0] CIC_VECTOR_ADDR = 13'h0004;
   localparam int CIC_NUM_SOURCES = 12;
   localparam logic [1:0] CIC_Q1 = 2'h0;
   localparam logic [1:0] CIC_Q4 = 2'h3;

   typedef enum logic [1:0] {
      CIC_ST_IDLE = 2'b00,
      CIC_ST_FLUSH = 2'b01,
      CIC_ST_VECTOR = 2'b10
   } cic_state_e;

endpackage

// *** cic_core_model.sv ***
// Behavioural core sequencer facing the interrupt controller.
// Assumes one-cycle entry and return pulses from the controller.
`timescale 1ns/1ns
module cic_core_model
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] q_phase,
   input wire logic push_pc,
   input wire logic [12:0] push_addr,
   input wire logic pop_pc,
   input wire logic load_vector,
   input wire logic [12:0] vector_pc,
   output logic [12:0] pc_current
);
   logic [12:0] stack_top;

   // One-deep stack is enough: no nested entry while global enable is clear
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc_current <= 13'h0100;
         stack_top <= 13'h0000;
      end
      else
      begin
         if (push_pc)
            stack_top <= push_addr;
         if (load_vector)
            pc_current <= vector_pc;
         else if (pop_pc)
            pc_current <= stack_top;
         else if (q_phase == 2'h3)
            pc_current <= pc_current + 13'h0001;
      end
   end
endmodule // cic_core_model

// *** tb.sv ***
// Self-checking bench of the core interrupt controller.
// Assumes the core model answers pushes, pops and vector loads.
`timescale 1ns/1ns
module tb;
   localparam logic [2:0] ctl_a = cic_pkg::CIC_OFF_CORE_CTL;
   localparam logic [2:0] pflag_a = cic_pkg::CIC_OFF_PERIPH_FLAG;
   localparam logic [2:0] pen_a = cic_pkg::CIC_OFF_PERIPH_EN;
   localparam logic [2:0] opt_a = cic_pkg::CIC_OFF_OPTION;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic timer_overflow_evt = 1'b0;
   logic port_change_evt = 1'b0;
   logic [7:0] periph_evt = 8'h00;
   logic ext_pin = 1'b0;
   logic return_from_irq_op = 1'b0;
   logic nibble_swap_op = 1'b0;
   logic alu_flags_we = 1'b0;
   logic sleep_active = 1'b0;
   logic [7:0] reg_rdata;
   logic [12:0] pc_current, push_addr, vector_pc;
   logic status_flags_we, wake_request, flush_prefetch, push_pc, pop_pc, load_vector;
   logic [1:0] q_phase;
   int errors = 0;
   int check_count = 0;

   always #2 clk = ~clk;

   cic_core_interrupt_control dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_overflow_evt(timer_overflow_evt),
      .port_change_evt(port_change_evt), .periph_evt(periph_evt), .aux_evt(1'b0), .ext_pin(ext_pin),
      .return_from_irq_op(return_from_irq_op), .nibble_swap_op(nibble_swap_op), .alu_flags_we(alu_flags_we),
      .sleep_active(sleep_active), .pc_current(pc_current), .status_flags_we(status_flags_we),
      .wake_request(wake_request), .flush_prefetch(flush_prefetch), .push_pc(push_pc), .push_addr(push_addr),
      .pop_pc(pop_pc), .load_vector(load_vector), .vector_pc(vector_pc), .q_phase(q_phase));

   cic_core_model core (.clk(clk), .rst_n(rst_n), .q_phase(q_phase), .push_pc(push_pc), .push_addr(push_addr),
      .pop_pc(pop_pc), .load_vector(load_vector), .vector_pc(vector_pc), .pc_current(pc_current));

   // ****************************************
   // Shared tasks
   // ****************************************
   task chk(input logic [12:0] got, input logic [12:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task rd_chk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk({5'h00, reg_rdata}, {5'h00, exp});
   endtask

   // Event pulse lands in a Q1 cycle so the latency figure is exact
   task fire(input int which);
      @(negedge clk);
      while (q_phase !== 2'h3)
         @(negedge clk);
      @(posedge clk);
      if (which == 0)
         timer_overflow_evt <= 1'b1;
      else if (which == 1)
         port_change_evt <= 1'b1;
      else
         periph_evt <= 8'h01;
      @(negedge clk);
      @(posedge clk);
      timer_overflow_evt <= 1'b0;
      port_change_evt <= 1'b0;
      periph_evt <= 8'h00;
   endtask

   // Cycles until load_vector, -1 if none; also checks the pushed address
   task wait_vec(output int n);
      logic [12:0] pc_prev;
      n = -1;
      pc_prev = pc_current;
      for (int i = 1; i <= 24; i++)
      begin
         @(negedge clk);
         if (push_pc === 1'b1)
         begin
            chk(push_addr, pc_prev);
            chk({12'h000, flush_prefetch}, 13'h0001);
         end
         if (load_vector === 1'b1 && n < 0)
            n = i;
         pc_prev = pc_current;
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset;
      rd_chk(ctl_a, 8'h00);
      rd_chk(opt_a, 8'h40);
      rd_chk(3'h7, 8'h00);
   endtask

   task t_entry;
      int n;
      wr(ctl_a, 8'ha0);
      fire(0);
      wait_vec(n);
      // Counting starts one sample after the event edge
      chk(13'(n - 1), 13'h000c);
      chk(vector_pc, cic_pkg::CIC_VECTOR_ADDR);
      rd_chk(ctl_a, 8'h24);
      wr(ctl_a, 8'h28);
      fire(1);
      wait_vec(n);
      chk(13'(n), 13'h1fff);
      rd_chk(ctl_a, 8'h29);
      @(posedge clk);
      return_from_irq_op <= 1'b1;
      @(posedge clk);
      return_from_irq_op <= 1'b0;
      @(negedge clk);
      chk({12'h000, pop_pc}, 13'h0001);
      wait_vec(n);
      chk({12'h000, n > 0}, 13'h0001);
      wr(ctl_a, 8'h00);
   endtask

   task t_periph;
      int n;
      wr(pen_a, 8'h01);
      wr(ctl_a, 8'h80);
      fire(2);
      wait_vec(n);
      chk(13'(n), 13'h1fff);
      rd_chk(pflag_a, 8'h01);
      wr(ctl_a, 8'hc0);
      wait_vec(n);
      chk({12'h000, n > 0}, 13'h0001);
      wr(pflag_a, 8'h00);
      wr(ctl_a, 8'h00);
   endtask

   task t_pin;
      int n;
      for (int e = 1; e >= 0; e--)
      begin
         wr(opt_a, (e == 1) ? 8'h40 : 8'h00);
         wr(ctl_a, 8'h90);
         @(posedge clk);
         ext_pin <= (e == 1);
         wait_vec(n);
         chk({12'h000, n > 0}, 13'h0001);
         rd_chk(ctl_a, 8'h12);
         wr(ctl_a, 8'h00);
      end
   endtask

   task t_swap;
      @(posedge clk);
      alu_flags_we <= 1'b1;
      nibble_swap_op <= 1'b1;
      @(negedge clk);
      chk({12'h000, status_flags_we}, 13'h0000);
      @(posedge clk);
      nibble_swap_op <= 1'b0;
      @(negedge clk);
      chk({12'h000, status_flags_we}, 13'h0001);
      @(posedge clk);
      alu_flags_we <= 1'b0;
   endtask

   task t_sleep;
      int n;
      for (int g = 0; g <= 1; g++)
      begin
         wr(ctl_a, (g == 1) ? 8'ha8 : 8'h28);
         @(posedge clk);
         sleep_active <= 1'b1;
         fire(1);
         wait_vec(n);
         chk({12'h000, wake_request}, 13'h0001);
         chk(13'(n), 13'h1fff);
         @(posedge clk);
         sleep_active <= 1'b0;
         wait_vec(n);
         if (g == 0)
            chk(13'(n), 13'h1fff);
         else
            chk({12'h000, n >= 8}, 13'h0001);
         wr(ctl_a, 8'h00);
      end
   endtask

   // ****************************************
   // Sequence and verdict
   // ****************************************
   task print_verdict;
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset;
      t_entry;
      t_periph;
      t_pin;
      t_swap;
      t_sleep;
      print_verdict;
   end

   // Whole run needs well under 1000 cycles
   initial
   begin
      #40000;
      errors++;
      print_verdict;
   end
endmodule // tb
